// ---- tcc_pkg.sv ----
// Constants for the timer capture compare core
// Function
// - Count each tick, wrap past top to zero
// - Clear-on-match bit picks top in 8-bit without capture: maximum or compare A
// - Clock select zero gives no ticks
// - Counter readable and writable at any time
// - Counter write beats clear or increment
// - Overflow flag set on wrap from maximum
// - Capture source pin, or comparator when selected
// - Matching edge copies counter into capture register
// - Capture flag set in the copy cycle
// - Capture flag requests irq, cleared by service/write-one
// - Compare A is capture; 16-bit uses B too
// - Source switch may capture; software clears flag
// - Inputs synchronised; canceler adds four cycles delay
// - Filter output changes after four equal samples
// - Noise cancel bit enables filter on system clock
// - Driving the capture pin port triggers capture
// - Each capture overwrites the capture register
// - Compare match sets flag at next tick
// - 8-bit: flags A, B; 16-bit: A only; capture mode never sets A
// - Compare flags request irq, cleared by service/write-one
// - Counter write blocks matches for next tick
// - Mode set by width, capture, clear-on-match bits
// - Clear-on-match 8-bit without capture resets counter at compare A
// - 16-bit low byte access moves pair via temp, except compare reads without capture
package tcc_pkg;
  localparam logic [2:0] ADDR_CONTROL_A = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_B = 3'h1;
  localparam logic [2:0] ADDR_COUNT_LO  = 3'h2;
  localparam logic [2:0] ADDR_COUNT_HI  = 3'h3;
  localparam logic [2:0] ADDR_COMPARE_A = 3'h4;
  localparam logic [2:0] ADDR_COMPARE_B = 3'h5;
  localparam logic [2:0] ADDR_FLAGS     = 3'h6;
  localparam logic [2:0] ADDR_MASK      = 3'h7;
  // control_a fields
  localparam int BIT_CLEAR_ON_MATCH = 0;
  localparam int BIT_EDGE_RISING    = 1;
  localparam int BIT_COMP_CAPTURE   = 3;
  localparam int BIT_CAPTURE_MODE   = 6;
  localparam int BIT_WIDTH_16       = 7;
  // control_b fields
  localparam int BIT_NOISE_CANCEL   = 7;
  localparam int CLOCK_SEL_LSB      = 0;
  // flag and mask bit positions
  localparam int FLAG_OVERFLOW  = 0;
  localparam int FLAG_COMPARE_B = 1;
  localparam int FLAG_COMPARE_A = 2;
  localparam int FLAG_CAPTURE   = 3;
  // clock select codes
  localparam logic [2:0] CS_STOP      = 3'h0;
  localparam logic [2:0] CS_SYS       = 3'h1;
  localparam logic [2:0] CS_DIV8      = 3'h2;
  localparam logic [2:0] CS_DIV64     = 3'h3;
  localparam logic [2:0] CS_DIV256    = 3'h4;
  localparam logic [2:0] CS_DIV1024   = 3'h5;
  localparam logic [2:0] CS_EXT_FALL  = 3'h6;
  localparam logic [2:0] CS_EXT_RISE  = 3'h7;
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [15:0] MAX_8      = 16'h00ff;
  localparam logic [15:0] MAX_16     = 16'hffff;
  localparam logic [3:0]  FILTER_ONES = 4'hf;
endpackage

// ---- tcc_core.sv ----
// Timer counter with input capture and output compare, register port access
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tcc_core (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // Register port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       write_i,
  input  wire logic       read_i,
  output logic      [7:0] rdata_o,
  // Event inputs from outside the clock domain
  input  wire logic       capture_pin_i,
  input  wire logic       comparator_output_i,
  input  wire logic       external_count_pin_i,
  // Interrupt requests and service acknowledges
  output logic      [3:0] irq_o,
  input  wire logic [3:0] irq_ack_i
);
  typedef struct packed {
    logic [7:0]  control_a;
    logic [7:0]  control_b;
    logic [15:0] count_value;
    logic [7:0]  compare_a_value;
    logic [7:0]  compare_b_value;
    logic [7:0]  temp;
    logic [3:0]  flags;
    logic [3:0]  mask;
    logic [7:0]  rdata;
    logic        block;
    logic        pin_s1;
    logic        pin_s2;
    logic        cmp_s1;
    logic        cmp_s2;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_prev;
    logic [2:0]  hist;
    logic        filt;
    logic        edge_prev;
    logic [9:0]  presc;
  } tcc_state_type;

  tcc_state_type st;
  tcc_state_type next_st;

  logic        wide;
  logic        cap_mode;
  logic        timer_tick;
  logic [15:0] top;
  logic [15:0] max_val;
  logic        src;
  logic        det_in;
  logic [3:0]  samples;
  logic        cap_evt;
  logic        match_a;
  logic        match_b;
  logic        set_a;
  logic        set_b;
  logic        wr_cnt;
  logic [3:0]  clr;
  logic [3:0]  setf;
  logic [2:0]  cs;

  assign wide     = st.control_a[tcc_pkg::BIT_WIDTH_16];
  assign cap_mode = st.control_a[tcc_pkg::BIT_CAPTURE_MODE];
  assign cs       = st.control_b[tcc_pkg::CLOCK_SEL_LSB +: 3];
  assign max_val  = wide ? tcc_pkg::MAX_16 : tcc_pkg::MAX_8;

  // Tick generation; the prescaler runs free so the first tick may come early
  always_comb begin
    case (cs)
      tcc_pkg::CS_STOP:     timer_tick = 1'b0;
      tcc_pkg::CS_SYS:      timer_tick = 1'b1;
      tcc_pkg::CS_DIV8:     timer_tick = &st.presc[2:0];
      tcc_pkg::CS_DIV64:    timer_tick = &st.presc[5:0];
      tcc_pkg::CS_DIV256:   timer_tick = &st.presc[7:0];
      tcc_pkg::CS_DIV1024:  timer_tick = &st.presc;
      tcc_pkg::CS_EXT_FALL: timer_tick = st.ext_prev & ~st.ext_s2;
      default:              timer_tick = ~st.ext_prev & st.ext_s2;
    endcase
  end

  // Top is compare A only in 8-bit clear-on-match without capture
  assign top = (st.control_a[tcc_pkg::BIT_CLEAR_ON_MATCH] && !wide && !cap_mode) ?
               {8'h00, st.compare_a_value} : max_val;

  // Capture path: synchronised sources, optional filter, edge detector
  assign src    = st.control_a[tcc_pkg::BIT_COMP_CAPTURE] ? st.cmp_s2 : st.pin_s2;
  assign det_in = st.control_b[tcc_pkg::BIT_NOISE_CANCEL] ? st.filt : src;
  // Three held samples plus the arriving one, so the filter adds exactly four cycles
  assign samples = {st.hist, src};
  assign cap_evt = cap_mode && (st.control_a[tcc_pkg::BIT_EDGE_RISING] ?
                   (det_in & ~st.edge_prev) : (~det_in & st.edge_prev));

  // Compare units; in 16-bit the pair forms one unit, none in 16-bit capture
  assign match_a = wide ? (st.count_value == {st.compare_b_value, st.compare_a_value}) :
                   (st.count_value[7:0] == st.compare_a_value);
  assign match_b = st.count_value[7:0] == st.compare_b_value;
  assign set_a   = timer_tick && !st.block && match_a && !cap_mode;
  assign set_b   = timer_tick && !st.block && match_b && !wide;

  assign wr_cnt = write_i &&
                  (addr_i == tcc_pkg::ADDR_COUNT_LO || addr_i == tcc_pkg::ADDR_COUNT_HI);

  always_comb begin
    setf = 4'h0;
    setf[tcc_pkg::FLAG_OVERFLOW]  = timer_tick && st.count_value == max_val;
    setf[tcc_pkg::FLAG_COMPARE_A] = set_a;
    setf[tcc_pkg::FLAG_COMPARE_B] = set_b;
    setf[tcc_pkg::FLAG_CAPTURE]   = cap_evt;
    clr = irq_ack_i;
    if (write_i && addr_i == tcc_pkg::ADDR_FLAGS) begin
      clr = clr | wdata_i[3:0];
    end
  end

  always_comb begin
    next_st = st;
    next_st.presc     = st.presc + 10'h001;
    // Two-stage synchronisers; only the second stage is read by logic
    next_st.pin_s1    = capture_pin_i;
    next_st.pin_s2    = st.pin_s1;
    next_st.cmp_s1    = comparator_output_i;
    next_st.cmp_s2    = st.cmp_s1;
    next_st.ext_s1    = external_count_pin_i;
    next_st.ext_s2    = st.ext_s1;
    next_st.ext_prev  = st.ext_s2;
    next_st.hist      = {st.hist[1:0], src};
    if (samples == tcc_pkg::FILTER_ONES || samples == 4'h0) begin
      next_st.filt = src;
    end
    next_st.edge_prev = det_in;
    // Flags: a set in the same cycle as a clear wins
    next_st.flags = (st.flags & ~clr) | setf;
    // Counter
    if (timer_tick) begin
      next_st.block = 1'b0;
      if (st.count_value == top) begin
        next_st.count_value = 16'h0000;
      end else begin
        next_st.count_value = st.count_value + 16'h0001;
      end
    end
    // Capture overwrites whatever is stored, read or not
    if (cap_evt) begin
      next_st.compare_a_value = st.count_value[7:0];
      if (wide) begin
        next_st.compare_b_value = st.count_value[15:8];
      end
    end
    next_st.rdata = 8'h00;
    if (write_i) begin
      if (addr_i == tcc_pkg::ADDR_CONTROL_A) begin
        next_st.control_a = wdata_i;
      end else if (addr_i == tcc_pkg::ADDR_CONTROL_B) begin
        next_st.control_b = wdata_i;
      end else if (addr_i == tcc_pkg::ADDR_COUNT_LO) begin
        next_st.count_value = wide ? {st.temp, wdata_i} : {8'h00, wdata_i};
        next_st.block = 1'b1;
      end else if (addr_i == tcc_pkg::ADDR_COUNT_HI) begin
        next_st.temp  = wdata_i;
        next_st.block = 1'b1;
      end else if (addr_i == tcc_pkg::ADDR_COMPARE_A) begin
        next_st.compare_a_value = wdata_i;
        if (wide) begin
          next_st.compare_b_value = st.temp;
        end
      end else if (addr_i == tcc_pkg::ADDR_COMPARE_B) begin
        if (wide) begin
          next_st.temp = wdata_i;
        end else begin
          next_st.compare_b_value = wdata_i;
        end
      end else if (addr_i == tcc_pkg::ADDR_MASK) begin
        next_st.mask = wdata_i[3:0];
      end
    end else if (read_i) begin
      if (addr_i == tcc_pkg::ADDR_CONTROL_A) begin
        next_st.rdata = st.control_a;
      end else if (addr_i == tcc_pkg::ADDR_CONTROL_B) begin
        next_st.rdata = st.control_b;
      end else if (addr_i == tcc_pkg::ADDR_COUNT_LO) begin
        next_st.rdata = st.count_value[7:0];
        if (wide) begin
          next_st.temp = st.count_value[15:8];
        end
      end else if (addr_i == tcc_pkg::ADDR_COUNT_HI) begin
        next_st.rdata = wide ? st.temp : 8'h00;
      end else if (addr_i == tcc_pkg::ADDR_COMPARE_A) begin
        next_st.rdata = st.compare_a_value;
        if (wide && cap_mode) begin
          next_st.temp = st.compare_b_value;
        end
      end else if (addr_i == tcc_pkg::ADDR_COMPARE_B) begin
        // Plain compare pair holds a fixed value, so no temp is needed
        next_st.rdata = (wide && cap_mode) ? st.temp : st.compare_b_value;
      end else if (addr_i == tcc_pkg::ADDR_FLAGS) begin
        next_st.rdata = {4'h0, st.flags};
      end else begin
        next_st.rdata = {4'h0, st.mask};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign irq_o   = st.flags & st.mask;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  property p_stop;
    (cs == tcc_pkg::CS_STOP) && !wr_cnt |=> $stable(st.count_value);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");

  property p_wrap;
    timer_tick && (st.count_value == top) && !wr_cnt |=> st.count_value == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap at top");

  property p_write_wins;
    write_i && (addr_i == tcc_pkg::ADDR_COUNT_LO) && !wide && !cap_evt
      |=> st.count_value == {8'h00, $past(wdata_i)};
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("counter write lost");

  property p_overflow;
    timer_tick && (st.count_value == max_val) |=> st.flags[tcc_pkg::FLAG_OVERFLOW];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag missing");

  property p_capture;
    cap_evt && !write_i
      |=> (st.compare_a_value == $past(st.count_value[7:0])) && st.flags[tcc_pkg::FLAG_CAPTURE];
  endproperty
  a_capture: assert property (p_capture) else $error("capture value or flag wrong");

  property p_block;
    st.block && timer_tick && !st.flags[tcc_pkg::FLAG_COMPARE_A]
      |=> !st.flags[tcc_pkg::FLAG_COMPARE_A];
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after write");

  property p_compare;
    timer_tick && !st.block && match_a && !cap_mode |=> st.flags[tcc_pkg::FLAG_COMPARE_A];
  endproperty
  a_compare: assert property (p_compare) else $error("compare A flag missing");

  property p_wide_b;
    wide && !st.flags[tcc_pkg::FLAG_COMPARE_B] && !(write_i && addr_i == tcc_pkg::ADDR_FLAGS)
      |=> !st.flags[tcc_pkg::FLAG_COMPARE_B];
  endproperty
  a_wide_b: assert property (p_wide_b) else $error("compare B set in 16-bit mode");

  property p_filter;
    $changed(st.filt) |-> ($past(samples) == tcc_pkg::FILTER_ONES) || ($past(samples) == 4'h0);
  endproperty
  a_filter: assert property (p_filter) else $error("filter changed without four equal");

  property p_clear;
    write_i && (addr_i == tcc_pkg::ADDR_FLAGS) && wdata_i[tcc_pkg::FLAG_CAPTURE] && !cap_evt
      |=> !st.flags[tcc_pkg::FLAG_CAPTURE];
  endproperty
  a_clear: assert property (p_clear) else $error("capture flag not cleared");

  property p_cov_overflow;
    timer_tick && (st.count_value == max_val);
  endproperty
  c_overflow: cover property (p_cov_overflow);
  property p_cov_capture;
    cap_evt && wide;
  endproperty
  c_capture: cover property (p_cov_capture);
  property p_cov_compare;
    set_a ##[1:300] set_b;
  endproperty
  c_compare: cover property (p_cov_compare);
  property p_cov_ctc;
    timer_tick && top != max_val && st.count_value == top;
  endproperty
  c_ctc: cover property (p_cov_ctc);
endmodule
`default_nettype wire

// ---- tcc_event_src.sv ----
// Far-side event source for the capture pin and comparator output
`timescale 1ns/1ns
`default_nettype none
module tcc_event_src (
  // Clock
  input  wire logic core_clk_i,
  // Event lines
  output var logic  capture_pin_o,
  output var logic  comparator_output_o,
  output var logic  external_count_pin_o
);
  initial begin
    capture_pin_o = 1'b0;
    comparator_output_o = 1'b0;
    external_count_pin_o = 1'b0;
  end
  // Change after an edge, then hold long enough for the sampler to see it
  task automatic set_level(input bit comp, input bit lvl, input int hold);
    @(posedge core_clk_i);
    if (comp) comparator_output_o <= lvl;
    else capture_pin_o <= lvl;
    repeat (hold) @(posedge core_clk_i);
  endtask
  // Count pulses; each half period lasts two system clocks so the sampler sees it
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      external_count_pin_o <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      external_count_pin_o <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the timer capture compare core
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic       clk;
  logic       reset_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic       write_i;
  logic       read_i;
  logic [7:0] rdata_o;
  logic [3:0] irq_o;
  logic [3:0] irq_ack_i;
  logic       pin;
  logic       comp;
  logic       ext_pin;
  logic [7:0] rd_val;
  logic [7:0] first_val;
  logic [7:0] stamp;
  logic [7:0] exp_q[$];
  int         failures;
  int         check_count;

  tcc_core tcc_core_inst (
    .core_clk_i(clk), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .capture_pin_i(pin),
    .comparator_output_i(comp), .external_count_pin_i(ext_pin), .irq_o(irq_o),
    .irq_ack_i(irq_ack_i));
  tcc_event_src tcc_event_src_inst (
    .core_clk_i(clk), .capture_pin_o(pin), .comparator_output_o(comp),
    .external_count_pin_o(ext_pin));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk);
    write_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk);
    read_i <= 1'b0;
    @(negedge clk);
    rd_val = rdata_o;
  endtask

  task automatic flag_chk(input logic [7:0] m, input logic [7:0] exp);
    rd(tcc_pkg::ADDR_FLAGS);
    chk(rd_val & m, exp);
  endtask

  task automatic run(input logic [2:0] cs);
    wr(tcc_pkg::ADDR_CONTROL_B, {5'h00, cs});
  endtask

  // Counter stopped: stamp the count, then a rise and a fall on the source
  task automatic capture(input bit c);
    stamp = 8'($urandom());
    exp_q.push_back(stamp);
    wr(tcc_pkg::ADDR_COUNT_LO, stamp);
    tcc_event_src_inst.set_level(c, 1'b1, 12);
    tcc_event_src_inst.set_level(c, 1'b0, 12);
  endtask

  task automatic cap_chk();
    rd(tcc_pkg::ADDR_COMPARE_A);
    chk(rd_val, exp_q[$]);
    exp_q.delete();
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end

  initial begin
    reset_i = 1'b1;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    write_i = 1'b0;
    read_i = 1'b0;
    irq_ack_i = 4'h0;
    failures = 0;
    check_count = 0;
    void'($urandom(29858));
    repeat (3) @(posedge clk);
    reset_i <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0]);
      chk(rd_val, 8'h00);
    end
    wr(tcc_pkg::ADDR_COUNT_LO, 8'h10);
    repeat (10) @(posedge clk);
    rd(tcc_pkg::ADDR_COUNT_LO);
    chk(rd_val, 8'h10);
    // Running from the system clock across the wrap
    run(tcc_pkg::CS_SYS);
    wr(tcc_pkg::ADDR_COUNT_LO, 8'hfe);
    rd(tcc_pkg::ADDR_COUNT_LO);
    first_val = rd_val;
    chk(first_val, 8'hff);
    repeat (3) @(posedge clk);
    rd(tcc_pkg::ADDR_COUNT_LO);
    chk(rd_val - first_val, 8'h05);
    flag_chk(8'h01, 8'h01);
    // Clear on match: top becomes compare A
    wr(tcc_pkg::ADDR_COMPARE_A, 8'h05);
    wr(tcc_pkg::ADDR_FLAGS, 8'h0f);
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h01);
    wr(tcc_pkg::ADDR_COUNT_LO, 8'h00);
    rd(tcc_pkg::ADDR_COUNT_LO);
    chk(rd_val, 8'h01);
    repeat (3) @(posedge clk);
    rd(tcc_pkg::ADDR_COUNT_LO);
    chk(rd_val, 8'h00);
    flag_chk(8'h04, 8'h04);
    // A count write hides the match on the first tick after it
    run(tcc_pkg::CS_STOP);
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h00);
    wr(tcc_pkg::ADDR_COMPARE_A, 8'h90);
    wr(tcc_pkg::ADDR_COMPARE_B, 8'h40);
    wr(tcc_pkg::ADDR_COUNT_LO, 8'h40);
    wr(tcc_pkg::ADDR_FLAGS, 8'h0f);
    run(tcc_pkg::CS_SYS);
    run(tcc_pkg::CS_STOP);
    flag_chk(8'h06, 8'h00);
    wr(tcc_pkg::ADDR_COUNT_LO, 8'h3f);
    run(tcc_pkg::CS_SYS);
    run(tcc_pkg::CS_STOP);
    flag_chk(8'h06, 8'h02);
    // Capture from the pin, rising edge, two events before one read
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h42);
    wr(tcc_pkg::ADDR_FLAGS, 8'h0f);
    wr(tcc_pkg::ADDR_MASK, 8'h08);
    capture(1'b0);
    capture(1'b0);
    cap_chk();
    flag_chk(8'h08, 8'h08);
    chk({7'h00, irq_o[3]}, 8'h01);
    @(posedge clk);
    irq_ack_i <= 4'h8;
    @(posedge clk);
    irq_ack_i <= 4'h0;
    flag_chk(8'h08, 8'h00);
    // Falling edge selected, flag cleared by writing one
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h40);
    capture(1'b0);
    cap_chk();
    wr(tcc_pkg::ADDR_FLAGS, 8'h08);
    flag_chk(8'h08, 8'h00);
    // Comparator as source; switching may leave a stale flag
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h4a);
    wr(tcc_pkg::ADDR_FLAGS, 8'h08);
    capture(1'b1);
    cap_chk();
    // Noise canceler swallows a two-cycle glitch, passes a steady level
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h42);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h80);
    wr(tcc_pkg::ADDR_FLAGS, 8'h0f);
    tcc_event_src_inst.set_level(1'b0, 1'b1, 1);
    tcc_event_src_inst.set_level(1'b0, 1'b0, 12);
    flag_chk(8'h08, 8'h00);
    capture(1'b0);
    cap_chk();
    // Prescaler tap and the event pin as tick sources: 4 + 3 + 2 ticks
    wr(tcc_pkg::ADDR_COUNT_LO, 8'h00);
    run(tcc_pkg::CS_DIV8);
    repeat (30) @(posedge clk);
    run(tcc_pkg::CS_STOP);
    run(tcc_pkg::CS_EXT_RISE);
    tcc_event_src_inst.ext_pulses(3);
    run(tcc_pkg::CS_STOP);
    run(tcc_pkg::CS_EXT_FALL);
    tcc_event_src_inst.ext_pulses(2);
    repeat (3) @(posedge clk);
    run(tcc_pkg::CS_STOP);
    rd(tcc_pkg::ADDR_COUNT_LO);
    chk(rd_val, 8'h09);
    // Wide capture: both count bytes land, high byte read through the holding byte
    wr(tcc_pkg::ADDR_CONTROL_A, 8'hc2);
    first_val = 8'($urandom());
    wr(tcc_pkg::ADDR_COUNT_HI, first_val);
    capture(1'b0);
    cap_chk();
    rd(tcc_pkg::ADDR_COMPARE_B);
    chk(rd_val, first_val);
    // Wide mode: high byte through the shared holding byte
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h00);
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h80);
    wr(tcc_pkg::ADDR_COUNT_HI, 8'h12);
    wr(tcc_pkg::ADDR_COUNT_LO, 8'h34);
    rd(tcc_pkg::ADDR_COUNT_LO);
    chk(rd_val, 8'h34);
    rd(tcc_pkg::ADDR_COUNT_HI);
    chk(rd_val, 8'h12);
    @(negedge clk);
    chk(rdata_o, 8'h00);
    // Wide compare: one unit, so only flag A may rise
    wr(tcc_pkg::ADDR_COMPARE_B, 8'h12);
    wr(tcc_pkg::ADDR_COMPARE_A, 8'h35);
    wr(tcc_pkg::ADDR_FLAGS, 8'h0f);
    run(tcc_pkg::CS_SYS);
    run(tcc_pkg::CS_STOP);
    flag_chk(8'h06, 8'h04);
    wr(tcc_pkg::ADDR_MASK, 8'h04);
    @(negedge clk);
    chk({4'h0, irq_o}, 8'h04);
    close_out();
  end
endmodule
`default_nettype wire
